// *** common/task_fault_pkg.sv ***
// Constants and types shared by the task switch and fault control block
package task_fault_pkg;
	localparam logic [15:0] TSB_MIN_LIMIT = 16'h002B;
	localparam int NESTED_FLAG_POS = 14;
	localparam logic [3:0] TYPE_AVAIL = 4'h1;
	localparam logic [3:0] TYPE_BUSY = 4'h3;
	localparam logic [7:0] VEC_COPROC_NA = 8'h07;
	localparam logic [7:0] VEC_DOUBLE = 8'h08;
	localparam logic [7:0] VEC_COPROC_OVR = 8'h09;
	localparam logic [7:0] VEC_BAD_TASK = 8'h0A;
	localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
	localparam logic [7:0] VEC_STACK = 8'h0C;
	localparam logic [7:0] VEC_GEN_PROT = 8'h0D;
	localparam logic [15:0] RESET_CODE_SEG = 16'hF000;
	localparam logic [15:0] RESET_INSTR_PTR = 16'hFFF0;
	localparam logic [15:0] SP_WRAP_LO0 = 16'h0000;
	localparam logic [15:0] SP_WRAP_LO1 = 16'h0001;
	localparam logic [15:0] SP_WRAP_HI0 = 16'hFFFE;
	localparam logic [15:0] SP_WRAP_HI1 = 16'hFFFF;
	localparam logic [3:0] UPPER_ADDR_HIGH = 4'hF;
	localparam logic [3:0] UPPER_ADDR_LOW = 4'h0;

	typedef enum logic [1:0]
	{
		SW_JUMP = 2'b00,
		SW_CALL = 2'b01,
		SW_INT = 2'b10,
		SW_RETURN = 2'b11
	} switch_cause_e;

	typedef enum logic [1:0]
	{
		FS_NORMAL = 2'b00,
		FS_DOUBLE = 2'b01,
		FS_SHUTDOWN = 2'b10
	} fault_state_e;

	typedef enum logic [1:0]
	{
		PT_ADJUST = 2'b00,
		PT_VERIFY_RD = 2'b01,
		PT_VERIFY_WR = 2'b10,
		PT_LOAD = 2'b11
	} ptr_test_e;
endpackage

// *** common/fault_vec_if.sv ***
// Exception request and vector result between the controller and its vector decoder
`timescale 1ns/100ps
interface fault_vec_if;
	import task_fault_pkg::*;
	logic [7:0] vector;
	logic pushCode;
	logic atFault;
	logic restartable;
	logic [15:0] savedSp;
	modport ctrl (output vector, output savedSp, input pushCode, input atFault, input restartable);
	modport dec (input vector, input savedSp, output pushCode, output atFault, output restartable);
endinterface

// *** verilog/fault_vector_decode.sv ***
// Per-vector attributes of protected mode exceptions
`timescale 1ns/100ps
module fault_vector_decode
	import task_fault_pkg::*;
(
	fault_vec_if.dec vec
);
	function automatic logic spWrapped(input logic [15:0] sp);
		spWrapped = (sp == SP_WRAP_LO0) || (sp == SP_WRAP_LO1) ||
			(sp == SP_WRAP_HI0) || (sp == SP_WRAP_HI1);
	endfunction

	always_comb
	begin
		vec.pushCode = 1'b0;
		vec.atFault = 1'b1;
		vec.restartable = 1'b0;
		case (vec.vector)
			VEC_COPROC_OVR:
			begin
				vec.atFault = 1'b0;
			end
			VEC_DOUBLE, VEC_GEN_PROT:
			begin
				vec.pushCode = 1'b1;
			end
			VEC_BAD_TASK, VEC_NOT_PRESENT:
			begin
				vec.pushCode = 1'b1;
				vec.restartable = 1'b1;
			end
			VEC_STACK:
			begin
				vec.pushCode = 1'b1;
				// Stack wrap by push-all or pop-all cannot be resumed
				vec.restartable = !spWrapped(vec.savedSp);
			end
			default:
			begin
				vec.atFault = 1'b1;
			end
		endcase
	end
endmodule

// *** verilog/task_switch_fault_control.sv ***
// Task switch, fault sequencing and pointer test control
`timescale 1ns/100ps
// Summary of operation
// - Task state descriptor usable only if its limit exceeds 002B hex.
// - Nested-task flag lives at flag bit 14 and steers interrupt return.
// - Interrupt return pops stack when nested clear, else switches back to task.
// - Switch other than return marks new block busy, old busy unless jump, writes back link.
// - Nested flag of incoming task set for call or interrupt, not jump.
// - Interrupt without task switch clears the nested flag.
// - Busy is marked by rewriting descriptor type 1 to type 3.
// - Using a selector of an already busy block raises general protection.
// - Coprocessor overrun on vector 9, no error code, not at escape.
// - Error code for 8,10-13; only 10, 11, 12 restartable.
// - Push-all or pop-all stack wrap faults are non-restartable, boundary stack pointer.
// - Every task switch sets task-switched flag; coprocessor context left alone.
// - Escape or wait with task-switched and coprocessor-present raises vector 7.
// - Two exceptions in one instruction cause the double fault.
// - Exception during double fault enters shutdown, which blocks task switches and further faults.
// - Shutdown left by non-maskable interrupt, or by reset into real mode.
// - Shutdown is announced by a halt bus cycle with address line one low.
// - Reset starts real mode fetching at F000:FFF0.
// - Top address lines high for code until code segment reloaded, else low.
// - Task selector load also loads its hidden base and limit.
// - Verify instructions set zero when segment readable or writable.
// - Privilege adjust takes maximum, zero on change; limit and rights load zero on success.
module task_switch_fault_control
	import task_fault_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Task switch request
	input wire logic switchReq,
	input wire switch_cause_e switchCause,
	input wire logic [15:0] newSelector,
	input wire logic [15:0] descLimit,
	input wire logic [3:0] descType,
	input wire logic [23:0] descBase,
	input wire logic [15:0] linkSelector,
	// Task selector register load
	input wire logic taskSelLoad,
	// Interrupt service and interrupt return
	input wire logic intNoSwitch,
	input wire logic iretReq,
	input wire logic flagWrite,
	input wire logic [15:0] flagWriteData,
	// Machine status word load
	input wire logic statusWordLoad,
	input wire logic [3:0] statusWordData,
	// Coprocessor use
	input wire logic coprocInstr,
	// Exceptions
	input wire logic faultReq,
	input wire logic [7:0] faultVector,
	input wire logic [15:0] faultSp,
	input wire logic instrDone,
	input wire logic nmiReq,
	// Segment reference
	input wire logic codeSegLoad,
	input wire logic codeSegRef,
	// Pointer test
	input wire logic ptrTestReq,
	input wire ptr_test_e ptrTestOp,
	input wire logic [1:0] selPrivilege,
	input wire logic [1:0] regPrivilege,
	input wire logic segReadable,
	input wire logic segWritable,
	input wire logic ptrAccessOk,
	// Task switch results
	output logic switchGo,
	output logic iretPops,
	output logic markOldBusy,
	output logic markNewBusy,
	output logic [3:0] busyType,
	output logic [15:0] backLink,
	output logic [15:0] task_selector_register,
	output logic [23:0] taskBase,
	output logic [15:0] taskLimit,
	output logic [15:0] flags,
	output logic [3:0] machine_status_word,
	// Exception results
	output logic excValid,
	output logic [7:0] excVector,
	output logic excPushCode,
	output logic excAtFault,
	output logic excRestartable,
	output logic shutdown,
	output logic haltCycle,
	output logic haltAddr1,
	// Addressing and pointer test results
	output logic [3:0] upperAddr,
	output logic [15:0] resetCodeSeg,
	output logic [15:0] resetInstrPtr,
	output logic zero_flag,
	output logic [1:0] adjustedPrivilege
);
	localparam int TS_POS = 3;
	localparam int MP_POS = 1;
	localparam int PE_POS = 0;

	function automatic logic tsbUsable(input logic [15:0] lim, input logic [3:0] typ);
		tsbUsable = (lim > TSB_MIN_LIMIT) && (typ == TYPE_AVAIL);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	logic [15:0] flags_q, flags_d;
	logic [3:0] msw_q, msw_d;
	logic [15:0] tsel_q, tsel_d;
	logic [23:0] tbase_q, tbase_d;
	logic [15:0] tlim_q, tlim_d;
	logic [15:0] link_q, link_d;
	logic oldBusy_q, oldBusy_d;
	logic newBusy_q, newBusy_d;
	logic go_q, go_d;
	logic pops_q, pops_d;
	logic busyFault;

	always_comb
	begin
		flags_d = flags_q;
		msw_d = msw_q;
		tsel_d = tsel_q;
		tbase_d = tbase_q;
		tlim_d = tlim_q;
		link_d = link_q;
		oldBusy_d = 1'b0;
		newBusy_d = 1'b0;
		go_d = 1'b0;
		pops_d = 1'b0;
		busyFault = 1'b0;
		if (flagWrite)
			flags_d = flagWriteData;
		if (statusWordLoad)
			msw_d = statusWordData | {3'b000, msw_q[PE_POS]};
		if (intNoSwitch)
			flags_d[NESTED_FLAG_POS] = 1'b0;
		if (iretReq && !flags_q[NESTED_FLAG_POS])
			pops_d = 1'b1;
		if (switchReq && !shutdown)
		begin
			if (switchCause == SW_RETURN || tsbUsable(descLimit, descType))
			begin
				go_d = 1'b1;
				newBusy_d = (switchCause != SW_RETURN);
				oldBusy_d = (switchCause == SW_CALL) || (switchCause == SW_INT);
				if (switchCause != SW_RETURN)
					link_d = tsel_q;
				flags_d = flagWriteData;
				// Incoming nested flag comes from the new task unless call or interrupt
				if (switchCause == SW_CALL || switchCause == SW_INT)
					flags_d[NESTED_FLAG_POS] = 1'b1;
				msw_d[TS_POS] = 1'b1;
				tsel_d = newSelector;
				tbase_d = descBase;
				tlim_d = descLimit;
			end
			else
				busyFault = 1'b1;
		end
		else if (taskSelLoad)
		begin
			tsel_d = newSelector;
			tbase_d = descBase;
			tlim_d = descLimit;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			flags_q <= 16'h0002;
			msw_q <= 4'h0;
			tsel_q <= 16'h0000;
			tbase_q <= 24'h000000;
			tlim_q <= 16'h0000;
			link_q <= 16'h0000;
			oldBusy_q <= 1'b0;
			newBusy_q <= 1'b0;
			go_q <= 1'b0;
			pops_q <= 1'b0;
		end
		else
		begin
			flags_q <= flags_d;
			msw_q <= msw_d;
			tsel_q <= tsel_d;
			tbase_q <= tbase_d;
			tlim_q <= tlim_d;
			link_q <= link_d;
			oldBusy_q <= oldBusy_d;
			newBusy_q <= newBusy_d;
			go_q <= go_d;
			pops_q <= pops_d;
		end
	end

	assign switchGo = go_q;
	assign iretPops = pops_q;
	assign markOldBusy = oldBusy_q;
	assign markNewBusy = newBusy_q;
	assign busyType = TYPE_BUSY;
	assign backLink = link_q;
	assign task_selector_register = tsel_q;
	assign taskBase = tbase_q;
	assign taskLimit = tlim_q;
	assign flags = flags_q;
	assign machine_status_word = msw_q;

	////////////////////////////////////////////////////////////////////////////
	fault_state_e fstate_q, fstate_d;
	logic excPend_q, excPend_d;
	logic [7:0] vec_q, vec_d;
	logic [15:0] sp_q, sp_d;
	logic halt_q, halt_d;
	logic coprocFault;
	logic anyFault;
	logic [7:0] rawVec;
	fault_vec_if vecBus ();

	// Coprocessor escape or wait traps while a stale context may be loaded
	assign coprocFault = coprocInstr && msw_q[TS_POS] && msw_q[MP_POS];
	assign anyFault = faultReq || coprocFault || busyFault;
	always_comb
	begin
		if (busyFault)
			rawVec = VEC_GEN_PROT;
		else if (coprocFault)
			rawVec = VEC_COPROC_NA;
		else
			rawVec = faultVector;
	end

	always_comb
	begin
		fstate_d = fstate_q;
		// Pending exception stands until the instruction boundary; a new fault wins
		excPend_d = excPend_q && !instrDone;
		vec_d = vec_q;
		sp_d = sp_q;
		halt_d = 1'b0;
		case (fstate_q)
			FS_NORMAL:
			begin
				if (anyFault)
				begin
					// Second fault of the same instruction escalates
					if (excPend_q)
					begin
						vec_d = VEC_DOUBLE;
					end
					else
						vec_d = rawVec;
					excPend_d = 1'b1;
					sp_d = faultSp;
					if (excPend_q)
						fstate_d = FS_DOUBLE;
				end
			end
			FS_DOUBLE:
			begin
				if (anyFault)
				begin
					fstate_d = FS_SHUTDOWN;
					halt_d = 1'b1;
				end
				else if (instrDone)
					fstate_d = FS_NORMAL;
			end
			FS_SHUTDOWN:
			begin
				// Everything but the non-maskable interrupt is ignored here
				if (nmiReq)
				begin
					fstate_d = FS_NORMAL;
					excPend_d = 1'b0;
				end
			end
			default:
			begin
				fstate_d = FS_NORMAL;
			end
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			fstate_q <= FS_NORMAL;
			excPend_q <= 1'b0;
			vec_q <= 8'h00;
			sp_q <= 16'h0000;
			halt_q <= 1'b0;
		end
		else
		begin
			fstate_q <= fstate_d;
			excPend_q <= excPend_d;
			vec_q <= vec_d;
			sp_q <= sp_d;
			halt_q <= halt_d;
		end
	end

	assign vecBus.vector = vec_q;
	assign vecBus.savedSp = sp_q;

	fault_vector_decode decoder
	(
		.vec(vecBus)
	);

	assign excValid = excPend_q;
	assign excVector = vec_q;
	assign excPushCode = vecBus.pushCode;
	assign excAtFault = vecBus.atFault;
	assign excRestartable = vecBus.restartable;
	assign shutdown = (fstate_q == FS_SHUTDOWN);
	assign haltCycle = halt_q;
	assign haltAddr1 = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	logic csLoaded_q, csLoaded_d;
	logic zf_q, zf_d;
	logic [1:0] adj_q, adj_d;

	always_comb
	begin
		csLoaded_d = csLoaded_q || codeSegLoad;
		zf_d = zf_q;
		adj_d = adj_q;
		if (ptrTestReq)
		begin
			case (ptrTestOp)
				PT_ADJUST:
				begin
					adj_d = (regPrivilege > selPrivilege) ? regPrivilege : selPrivilege;
					zf_d = regPrivilege > selPrivilege;
				end
				PT_VERIFY_RD:
					zf_d = segReadable;
				PT_VERIFY_WR:
					zf_d = segWritable;
				PT_LOAD:
					zf_d = ptrAccessOk;
				default:
					zf_d = zf_q;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_b)
		begin
			csLoaded_q <= 1'b0;
			zf_q <= 1'b0;
			adj_q <= 2'b00;
		end
		else
		begin
			csLoaded_q <= csLoaded_d;
			zf_q <= zf_d;
			adj_q <= adj_d;
		end
	end

	// Real mode reset start lets boot code sit at the top of memory
	assign upperAddr = (codeSegRef && !csLoaded_q) ? UPPER_ADDR_HIGH : UPPER_ADDR_LOW;
	assign resetCodeSeg = RESET_CODE_SEG;
	assign resetInstrPtr = RESET_INSTR_PTR;
	assign zero_flag = zf_q;
	assign adjustedPrivilege = adj_q;
endmodule

// *** testbench/irq_source_model.sv ***
// Model of the external non-maskable interrupt source
`timescale 1ns/100ps
module irq_source_model
(
	// Clock
	input wire logic sys_clk,
	// Request from the bench
	input wire logic fire,
	// Interrupt line to the block
	output logic nmiReq
);
	logic armed_q = 1'b0;
	initial nmiReq = 1'b0;
	always @(posedge sys_clk) armed_q <= fire;
	// Launched off the falling edge so the block samples a settled line
	always @(negedge sys_clk) nmiReq <= armed_q;
endmodule

// *** testbench/task_fault_sva.sv ***
// Assertions on the task switch and fault control ports
`timescale 1ns/100ps
module task_fault_sva
	import task_fault_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Requests
	input wire logic switchReq,
	input wire switch_cause_e switchCause,
	input wire logic [15:0] descLimit,
	input wire logic [3:0] descType,
	input wire logic iretReq,
	input wire logic coprocInstr,
	input wire logic faultReq,
	input wire logic instrDone,
	input wire logic nmiReq,
	input wire logic codeSegLoad,
	input wire logic codeSegRef,
	// Results
	input wire logic switchGo,
	input wire logic markOldBusy,
	input wire logic markNewBusy,
	input wire logic [15:0] flags,
	input wire logic [3:0] machine_status_word,
	input wire logic iretPops,
	input wire logic excValid,
	input wire logic [7:0] excVector,
	input wire logic shutdown,
	input wire logic haltCycle,
	input wire logic haltAddr1,
	input wire logic [3:0] upperAddr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic csLoaded_q;
	logic csLoaded_d;
	always_comb csLoaded_d = csLoaded_q | codeSegLoad;
	always_ff @(posedge sys_clk) csLoaded_q <= rst_b ? csLoaded_d : 1'b0;
	sequence s_quiet;
		!excValid && !shutdown && !faultReq;
	endsequence
	sequence s_double_held;
		excValid && excVector == VEC_DOUBLE && !instrDone && !shutdown;
	endsequence
	sequence s_good_desc;
		descLimit > TSB_MIN_LIMIT && descType == TYPE_AVAIL;
	endsequence
	////////////////////////////////////////////////////////////////
	a_call_marks_busy: assert property (switchReq && switchCause == SW_CALL ##0 s_good_desc ##0 s_quiet |=> switchGo && markOldBusy && markNewBusy && flags[NESTED_FLAG_POS])
		else $error("call switch result wrong");
	a_bad_desc_refused: assert property (switchReq && switchCause != SW_RETURN && !(descLimit > TSB_MIN_LIMIT && descType == TYPE_AVAIL) ##0 s_quiet |=> !switchGo && excValid && excVector == VEC_GEN_PROT)
		else $error("bad descriptor not refused");
	a_ts_on_switch: assert property (switchGo |-> machine_status_word[3])
		else $error("task switched flag not set");
	a_interrupt_return_instr_pops: assert property (iretPops |-> $past(iretReq) && !$past(flags[NESTED_FLAG_POS]))
		else $error("interrupt return pop mismatch");
	a_coproc_trap: assert property (coprocInstr && machine_status_word[3] && machine_status_word[1] ##0 s_quiet |=> excValid && excVector == VEC_COPROC_NA)
		else $error("coprocessor trap missing");
	a_double_fault: assert property (faultReq && excValid && excVector != VEC_DOUBLE && !instrDone && !shutdown |=> excValid && excVector == VEC_DOUBLE)
		else $error("double fault missing");
	a_shutdown_entry: assert property (s_double_held ##0 faultReq |=> shutdown && haltCycle && !haltAddr1)
		else $error("shutdown entry wrong");
	a_nmi_exit: assert property (shutdown && nmiReq |=> !shutdown)
		else $error("shutdown not left on nmi");
	a_upper_addr: assert property (upperAddr == ((codeSegRef && !csLoaded_q) ? UPPER_ADDR_HIGH : UPPER_ADDR_LOW))
		else $error("upper address lines wrong");
endmodule
bind task_switch_fault_control task_fault_sva sva_u (.*);

// *** testbench/task_switch_fault_control_tb.sv ***
// Self-checking bench for the task switch and fault control block
`timescale 1ns/100ps
module task_switch_fault_control_tb;
	import task_fault_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic nmiFire = 1'b0;
	logic switchReq, taskSelLoad, intNoSwitch, iretReq, flagWrite, statusWordLoad, coprocInstr;
	logic faultReq, instrDone, nmiReq, codeSegLoad, codeSegRef, ptrTestReq;
	logic segReadable, segWritable, ptrAccessOk;
	switch_cause_e switchCause = SW_JUMP;
	ptr_test_e ptrTestOp = PT_ADJUST;
	logic [15:0] newSelector, descLimit, linkSelector, flagWriteData, faultSp;
	logic [3:0] descType, statusWordData;
	logic [23:0] descBase;
	logic [7:0] faultVector;
	logic [1:0] selPrivilege, regPrivilege;
	logic switchGo, iretPops, markOldBusy, markNewBusy, excValid, excPushCode, excAtFault;
	logic excRestartable, shutdown, haltCycle, haltAddr1, zero_flag;
	logic [3:0] busyType, machine_status_word, upperAddr;
	logic [15:0] backLink, task_selector_register, taskLimit, flags, resetCodeSeg, resetInstrPtr;
	logic [23:0] taskBase;
	logic [7:0] excVector;
	logic [1:0] adjustedPrivilege;
	int n_errors = 0;
	int compares = 0;
	int cycles = 0;
	task_switch_fault_control dut_u (.*);
	irq_source_model irq_u (.sys_clk(sys_clk), .fire(nmiFire), .nmiReq(nmiReq));
	always #12.5 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Results are read at the falling edge after the taking edge
	task automatic pulse(ref logic sig);
		@(negedge sys_clk);
		sig = 1'b1;
		@(negedge sys_clk);
		sig = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_switch;
		newSelector = 16'h0010;
		descBase = 24'h012340;
		descLimit = 16'h0100;
		descType = TYPE_AVAIL;
		pulse(taskSelLoad);
		chk("sel", 16'h0010, task_selector_register);
		chk("base", 24'h012340, taskBase);
		chk("limit", 16'h0100, taskLimit);
		// Jump, call, then interrupt; just above the minimum limit
		for (int i = 0; i < 3; i++)
		begin
			switchCause = switch_cause_e'(i);
			newSelector = 16'h0020 + 16'(i);
			descLimit = 16'h002C;
			pulse(switchReq);
			chk("go", 1, switchGo);
			chk("newBusy", 1, markNewBusy);
			chk("oldBusy", i != 0, markOldBusy);
			chk("link", i == 0 ? 16'h0010 : 16'h001F + 16'(i), backLink);
			chk("nested", i != 0, flags[NESTED_FLAG_POS]);
			chk("ts", 1, machine_status_word[3]);
			chk("busyType", TYPE_BUSY, busyType);
		end
	endtask
	task automatic t_refuse;
		switchCause = SW_CALL;
		for (int i = 0; i < 2; i++)
		begin
			descLimit = i ? 16'h0100 : TSB_MIN_LIMIT;
			descType = i ? TYPE_BUSY : TYPE_AVAIL;
			pulse(switchReq);
			chk("go", 0, switchGo);
			chk("exc", 1, excValid);
			chk("vec", VEC_GEN_PROT, excVector);
			pulse(instrDone);
		end
	endtask
	task automatic t_interrupt_return_instr;
		pulse(iretReq);
		chk("pops", 0, iretPops);
		pulse(intNoSwitch);
		chk("nested", 0, flags[NESTED_FLAG_POS]);
		pulse(iretReq);
		chk("pops", 1, iretPops);
	endtask
	task automatic t_coproc;
		for (int i = 0; i < 2; i++)
		begin
			statusWordData = i ? 4'h9 : 4'hB;
			pulse(statusWordLoad);
			pulse(coprocInstr);
			chk("exc", i == 0, excValid);
			chk("vec", VEC_COPROC_NA, excVector);
			pulse(instrDone);
		end
	endtask
	task automatic t_vectors;
		logic [15:0] wrapSp [4] = '{16'h0000, 16'h0001, 16'hFFFE, 16'hFFFF};
		for (int i = 0; i < 9; i++)
		begin
			faultVector = (i < 5) ? 8'(9 + i) : VEC_STACK;
			faultSp = (i < 5) ? 16'h1000 : wrapSp[i-5];
			pulse(faultReq);
			chk("push", i != 0, excPushCode);
			chk("atFault", i != 0, excAtFault);
			chk("restart", i > 0 && i < 4, excRestartable);
			pulse(instrDone);
		end
	endtask
	task automatic t_ptr;
		logic e;
		for (int i = 0; i < 16; i++)
		begin
			selPrivilege = 2'(i);
			regPrivilege = 2'(i >> 2);
			pulse(ptrTestReq);
			chk("adj", (i >> 2) > (i & 3) ? i >> 2 : i & 3, adjustedPrivilege);
			chk("zAdj", (i >> 2) > (i & 3), zero_flag);
		end
		for (int i = 0; i < 8; i++)
		begin
			ptrTestOp = ptr_test_e'(1 + i % 3);
			{segReadable, segWritable, ptrAccessOk} = 3'(i);
			e = ptrTestOp == PT_VERIFY_RD ? segReadable : ptrAccessOk;
			e = ptrTestOp == PT_VERIFY_WR ? segWritable : e;
			pulse(ptrTestReq);
			chk("zTest", e, zero_flag);
		end
	endtask
	task automatic t_double;
		faultVector = VEC_GEN_PROT;
		pulse(faultReq);
		pulse(faultReq);
		chk("vec", VEC_DOUBLE, excVector);
		pulse(faultReq);
		chk("down", 1, shutdown);
		chk("halt", 1, haltCycle);
		chk("a1", 0, haltAddr1);
		descLimit = 16'h0100;
		descType = TYPE_AVAIL;
		pulse(switchReq);
		chk("go", 0, switchGo);
		pulse(nmiFire);
		@(negedge sys_clk);
		chk("down", 0, shutdown);
		chk("pe", 1, machine_status_word[0]);
		rst_b = 1'b0;
		repeat (2) @(negedge sys_clk);
		rst_b = 1'b1;
		chk("pe", 0, machine_status_word[0]);
	endtask
	task automatic t_upper;
		codeSegRef = 1'b0;
		#1 chk("up", UPPER_ADDR_LOW, upperAddr);
		codeSegRef = 1'b1;
		#1 chk("up", UPPER_ADDR_HIGH, upperAddr);
		pulse(codeSegLoad);
		#1 chk("up", UPPER_ADDR_LOW, upperAddr);
	endtask
	////////////////////////////////////////////////////////////////
	initial
	begin
		{switchReq, taskSelLoad, intNoSwitch, iretReq, flagWrite, statusWordLoad} = '0;
		{coprocInstr, faultReq, instrDone, codeSegLoad, codeSegRef, ptrTestReq} = '0;
		{segReadable, segWritable, ptrAccessOk, selPrivilege, regPrivilege} = '0;
		{newSelector, descLimit, linkSelector, flagWriteData, faultSp} = '0;
		{descType, statusWordData, descBase, faultVector} = '0;
		repeat (6) @(negedge sys_clk);
		rst_b = 1'b1;
		chk("flags", 16'h0002, flags);
		chk("cs", RESET_CODE_SEG, resetCodeSeg);
		chk("ip", RESET_INSTR_PTR, resetInstrPtr);
		t_switch();
		t_refuse();
		t_interrupt_return_instr();
		t_coproc();
		t_vectors();
		t_ptr();
		t_double();
		t_upper();
		end_of_test();
	end
endmodule
